// ### design/hdp_debounce.sv
// Sampled debounce filter with selectable resolution
`timescale 1ns/1ps
module hdp_debounce
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Control
	input wire logic tick_i,
	input wire logic [6:0] res_i,
	input wire logic raw_i,
	// Result
	output logic level_o,
	output logic smp_o
);

	hdp_pkg::hdp_db_t st;
	hdp_pkg::hdp_db_t nx;

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb
	begin
		nx = st;
		nx.smp = 1'b0;
		if (res_i == 7'h00)
		begin
			// No glitch rejection: follow the input directly
			nx.lvl = raw_i;
			nx.cnt = 3'h0;
			nx.div = 7'h00;
			nx.smp = tick_i;
		end
		else if (tick_i)
		begin
			if (st.div + 7'h01 >= res_i)
			begin
				nx.div = 7'h00;
				nx.smp = 1'b1;
				if (raw_i == st.lvl)
					nx.cnt = 3'h0;
				else if (st.cnt == 3'(hdp_pkg::DB_SAMPLES - 1))
				begin
					nx.lvl = raw_i;
					nx.cnt = 3'h0;
				end
				else
					nx.cnt = st.cnt + 3'h1;
			end
			else
				nx.div = st.div + 7'h01;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			st <= '0;
		else
			st <= nx;
	end

	assign level_o = st.lvl;
	assign smp_o = st.smp;

	// ************************************************************
	// Checks
	// ************************************************************
	db_flip_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$changed(st.lvl) && $past(res_i) != 7'h00 |-> $past(st.cnt) == 3'h7)
		else $error("debounced level changed before eight samples");

endmodule // hdp_debounce

// ### design/hdp_pkg.sv
// Shared constants and types for headset detect and output protection
package hdp_pkg;

	// ************************************************************
	// Register indices (byte address is index times four)
	// ************************************************************
	localparam logic [7:0] IDX_PWR = 8'h05;
	localparam logic [7:0] IDX_PROT = 8'h1d;
	localparam logic [7:0] IDX_HPCFG = 8'h20;
	localparam logic [7:0] IDX_PCFG = 8'h21;
	localparam logic [7:0] IDX_HS = 8'h22;
	localparam logic [7:0] IDX_POP = 8'h25;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int PWR_HPL = 12;
	localparam int PWR_HPR = 11;
	localparam int PWR_VG = 8;
	localparam int PWR_SPK = 7;
	localparam int PWR_RCV = 6;
	localparam int PROT_SWRST = 0;
	localparam int PROT_SHORT = 1;
	localparam int HPCFG_SCDIS = 0;
	localparam int PCFG_VGDIS = 4;
	localparam int PCFG_SPKEN = 5;
	localparam int HS_DETEN = 15;
	localparam int HS_PRES = 12;
	localparam int HS_BTN = 11;
	localparam int HS_DB_LO = 9;
	localparam int HS_MB = 8;
	localparam int HS_BDB_LO = 6;
	localparam int HS_G2 = 4;
	localparam int HS_G1 = 3;
	localparam int HS_BIRQ_LO = 0;
	localparam int POP_ST_LO = 10;
	localparam int POP_DIS = 5;
	localparam int POP_SEL = 4;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_PS = 8000;
	localparam int TICK_US = 250;
	localparam int TICK_CYCLES = (TICK_US * 1000 * 1000) / CLK_PERIOD_PS;
	localparam int HS_IRQ_US = 1750;
	localparam int BTN_DLY_US = 500;
	localparam int VG_UP_US = 1000;
	localparam int CHG_SHORT_US = 800000;
	localparam int CHG_LONG_US = 4000000;
	localparam int HS_RES_US = 2000;
	localparam int BTN_RES_US = 1000;
	localparam int HS_IRQ_TK = HS_IRQ_US / TICK_US;
	localparam int BTN_DLY_TK = BTN_DLY_US / TICK_US;
	localparam int VG_UP_TK = VG_UP_US / TICK_US;
	localparam int CHG_SHORT_TK = CHG_SHORT_US / TICK_US;
	localparam int CHG_LONG_TK = CHG_LONG_US / TICK_US;
	localparam int HS_RES_TK = HS_RES_US / TICK_US;
	localparam int BTN_RES_TK = BTN_RES_US / TICK_US;
	localparam int DB_SAMPLES = 8;

	// ************************************************************
	// State carriers
	// ************************************************************
	typedef struct packed {
		logic [6:0] div;
		logic [2:0] cnt;
		logic lvl;
		logic smp;
	} hdp_db_t;

	typedef struct packed {
		logic [4:0] pd;
		logic hp_scdis;
		logic vg_scdis;
		logic spk_scen;
		logic det_en;
		logic [1:0] hs_db;
		logic mb_en;
		logic [1:0] btn_db;
		logic g2;
		logic g1;
		logic [1:0] birq;
		logic pop_dis;
		logic pop_sel;
		logic short;
		logic hs_pres;
		logic btn_lvl;
		logic btn_flag;
		logic [2:0] hs_cnt;
		logic [1:0] bdly;
		logic btn_irq;
		logic [13:0] ramp;
		logic hp_up;
		logic [15:0] div;
		logic tick;
		logic hpl;
		logic hpr;
		logic vg;
		logic spk;
		logic rcv;
		logic mb;
		logic gp1;
		logic gp2;
		logic wr_pend;
		logic [7:0] wr_idx;
		logic [31:0] rdata;
		logic ready;
	} hdp_top_t;

	localparam logic [4:0] PD_RST = 5'h1f;
	localparam hdp_top_t TOP_RST = '{pd: PD_RST, ready: 1'b1, default: '0};

endpackage

// ### design/hdp_top.sv
// Headset detection and analog output protection control with AHB-Lite registers
`timescale 1ns/1ps
module hdp_top
#(
	parameter int TICK_CYCLES = hdp_pkg::TICK_CYCLES
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// Analog monitors
	input wire logic short_hp_i,
	input wire logic short_virtual_ground_amp_i,
	input wire logic short_spk_i,
	input wire logic headset_sense_i,
	input wire logic button_sense_i,
	// Driver enables
	output logic left_headphone_output_o,
	output logic right_headphone_output_o,
	output logic virtual_ground_amp_o,
	output logic speaker_diff_output_o,
	output logic receiver_diff_output_o,
	output logic headset_mic_bias_o,
	// Host interrupt pins
	output logic general_io_pin_one_o,
	output logic general_io_pin_two_o
);

	hdp_pkg::hdp_top_t st;
	hdp_pkg::hdp_top_t nx;
	logic hs_lvl;
	logic btn_lvl;
	logic btn_smp;
	logic [6:0] hs_res;
	logic [6:0] btn_res;
	logic [5:0] stat;
	logic short_det;
	logic forced;
	logic hp_req;
	logic hs_evt;
	logic addr_ok;
	logic rd_hs;
	logic swrst;
	logic vg_on;

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [6:0] res_tk(input int base, input logic [1:0] sh);
		res_tk = 7'(base << sh);
	endfunction

	function automatic logic [31:0] rd_word(input logic [7:0] idx, input hdp_pkg::hdp_top_t s,
		input logic [5:0] sv);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (idx)
			hdp_pkg::IDX_PWR:
			begin
				v[hdp_pkg::PWR_HPL] = s.pd[4];
				v[hdp_pkg::PWR_HPR] = s.pd[3];
				v[hdp_pkg::PWR_VG] = s.pd[2];
				v[hdp_pkg::PWR_SPK] = s.pd[1];
				v[hdp_pkg::PWR_RCV] = s.pd[0];
			end
			hdp_pkg::IDX_PROT: v[hdp_pkg::PROT_SHORT] = s.short;
			hdp_pkg::IDX_HPCFG: v[hdp_pkg::HPCFG_SCDIS] = s.hp_scdis;
			hdp_pkg::IDX_PCFG:
			begin
				v[hdp_pkg::PCFG_VGDIS] = s.vg_scdis;
				v[hdp_pkg::PCFG_SPKEN] = s.spk_scen;
			end
			hdp_pkg::IDX_HS:
			begin
				v[hdp_pkg::HS_DETEN] = s.det_en;
				v[hdp_pkg::HS_PRES] = s.hs_pres;
				v[hdp_pkg::HS_BTN] = s.btn_flag;
				v[hdp_pkg::HS_DB_LO +: 2] = s.hs_db;
				v[hdp_pkg::HS_MB] = s.mb_en;
				v[hdp_pkg::HS_BDB_LO +: 2] = s.btn_db;
				v[hdp_pkg::HS_G2] = s.g2;
				v[hdp_pkg::HS_G1] = s.g1;
				v[hdp_pkg::HS_BIRQ_LO +: 2] = s.birq;
			end
			hdp_pkg::IDX_POP:
			begin
				v[hdp_pkg::POP_ST_LO +: 6] = sv;
				v[hdp_pkg::POP_DIS] = s.pop_dis;
				v[hdp_pkg::POP_SEL] = s.pop_sel;
			end
			default: v = 32'h0000_0000;
		endcase
		rd_word = v;
	endfunction

	// ************************************************************
	// Debounce filters
	// ************************************************************
	assign hs_res = res_tk(hdp_pkg::HS_RES_TK, st.hs_db);
	assign btn_res = (st.btn_db == 2'h0) ? 7'h00 :
		res_tk(hdp_pkg::BTN_RES_TK, st.btn_db - 2'h1);

	hdp_debounce u_hs_db
	(
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.tick_i(st.tick),
		.res_i(hs_res),
		.raw_i(headset_sense_i & st.det_en),
		.level_o(hs_lvl),
		.smp_o()
	);

	hdp_debounce u_btn_db
	(
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.tick_i(st.tick),
		.res_i(btn_res),
		.raw_i(button_sense_i),
		.level_o(btn_lvl),
		.smp_o(btn_smp)
	);

	// ************************************************************
	// Combinational terms
	// ************************************************************
	// Each driver reads as powered down only once its request is off and its output has dropped
	assign stat = {st.pd[4] & ~st.hpl, st.pd[3] & ~st.hpr, st.pd[2] & ~st.vg,
		st.pd[1] & ~st.spk, st.pd[0] & ~st.rcv, ~st.hp_up};
	assign short_det = (short_hp_i & ~st.hp_scdis)
		| (short_virtual_ground_amp_i & ~st.vg_scdis)
		| (short_spk_i & st.spk_scen);
	assign forced = st.det_en & ~st.hs_pres;
	assign hp_req = ~st.pd[4] | ~st.pd[3];
	assign vg_on = ~st.pd[2] & ~st.short & ~forced;
	assign hs_evt = st.det_en & (hs_lvl != st.hs_pres);
	assign addr_ok = hsel_i & htrans_i[1] & hready_i & (hsize_i == 3'h2);
	assign rd_hs = addr_ok & ~hwrite_i & (haddr_i[9:2] == hdp_pkg::IDX_HS);
	assign swrst = st.wr_pend & (st.wr_idx == hdp_pkg::IDX_PROT) & hwdata_i[hdp_pkg::PROT_SWRST];

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb
	begin
		nx = st;
		nx.tick = 1'b0;
		if (st.div == 16'(TICK_CYCLES - 1))
		begin
			nx.div = 16'h0000;
			nx.tick = 1'b1;
		end
		else
			nx.div = st.div + 16'h0001;

		// Short state: a new detection wins over a completed recovery
		if (short_det)
			nx.short = 1'b1;
		else if (&stat)
			nx.short = 1'b0;

		// Headset presence and its interrupt pulse
		nx.hs_pres = hs_lvl;
		if (hs_evt)
			nx.hs_cnt = 3'(hdp_pkg::HS_IRQ_TK);
		else if (st.tick && st.hs_cnt != 3'h0)
			nx.hs_cnt = st.hs_cnt - 3'h1;

		// Button flag, delayed interrupt and release
		nx.btn_lvl = btn_lvl;
		if (btn_lvl && !st.btn_lvl)
		begin
			nx.btn_flag = 1'b1;
			nx.bdly = 2'(hdp_pkg::BTN_DLY_TK);
		end
		else
		begin
			if (rd_hs && !btn_lvl)
				nx.btn_flag = 1'b0;
			if (st.tick && st.bdly != 2'h0)
			begin
				nx.bdly = st.bdly - 2'h1;
				if (st.bdly == 2'h1)
					nx.btn_irq = 1'b1;
			end
		end
		// Released press ends the interrupt at the next sample
		if (btn_smp && !button_sense_i && st.bdly == 2'h0)
			nx.btn_irq = 1'b0;

		// Headphone powerup ramp
		nx.hp_up = hp_req & ~st.short;
		if (hp_req && !st.hp_up && !st.short)
		begin
			if (st.pop_dis)
				nx.ramp = 14'h0001;
			else if (vg_on)
				nx.ramp = 14'(hdp_pkg::VG_UP_TK);
			else if (st.pop_sel)
				nx.ramp = 14'(hdp_pkg::CHG_LONG_TK);
			else
				nx.ramp = 14'(hdp_pkg::CHG_SHORT_TK);
		end
		else if (st.tick && st.ramp != 14'h0000)
			nx.ramp = st.ramp - 14'h0001;

		// Driver enables
		nx.hpl = st.hp_up & (st.ramp == 14'h0000) & ~st.pd[4] & ~st.short & ~forced;
		nx.hpr = st.hp_up & (st.ramp == 14'h0000) & ~st.pd[3] & ~st.short;
		nx.vg = vg_on;
		nx.spk = ~st.pd[1] & ~st.short;
		nx.rcv = ~st.pd[0] & ~st.short & st.pd[4] & st.pd[3];
		nx.mb = st.mb_en & ~forced;
		nx.gp1 = ((st.hs_cnt != 3'h0) & st.g1) | (st.btn_irq & (st.birq != 2'h0));
		nx.gp2 = (st.hs_cnt != 3'h0) & st.g2;

		// Bus address phase
		if (addr_ok)
		begin
			nx.wr_pend = hwrite_i;
			nx.wr_idx = haddr_i[9:2];
			nx.rdata = hwrite_i ? 32'h0000_0000 : rd_word(haddr_i[9:2], st, stat);
		end
		else
			nx.wr_pend = 1'b0;

		// Bus data phase
		if (st.wr_pend)
		begin
			case (st.wr_idx)
				hdp_pkg::IDX_PWR: nx.pd = {hwdata_i[hdp_pkg::PWR_HPL], hwdata_i[hdp_pkg::PWR_HPR],
					hwdata_i[hdp_pkg::PWR_VG], hwdata_i[hdp_pkg::PWR_SPK],
					hwdata_i[hdp_pkg::PWR_RCV]};
				hdp_pkg::IDX_HPCFG: nx.hp_scdis = hwdata_i[hdp_pkg::HPCFG_SCDIS];
				hdp_pkg::IDX_PCFG:
				begin
					nx.vg_scdis = hwdata_i[hdp_pkg::PCFG_VGDIS];
					nx.spk_scen = hwdata_i[hdp_pkg::PCFG_SPKEN];
				end
				hdp_pkg::IDX_HS:
				begin
					nx.det_en = hwdata_i[hdp_pkg::HS_DETEN];
					nx.hs_db = hwdata_i[hdp_pkg::HS_DB_LO +: 2];
					nx.mb_en = hwdata_i[hdp_pkg::HS_MB];
					nx.btn_db = hwdata_i[hdp_pkg::HS_BDB_LO +: 2];
					nx.g2 = hwdata_i[hdp_pkg::HS_G2];
					nx.g1 = hwdata_i[hdp_pkg::HS_G1];
					nx.birq = hwdata_i[hdp_pkg::HS_BIRQ_LO +: 2];
				end
				hdp_pkg::IDX_POP:
				begin
					nx.pop_dis = hwdata_i[hdp_pkg::POP_DIS];
					nx.pop_sel = hwdata_i[hdp_pkg::POP_SEL];
				end
				default: nx.pd = nx.pd;
			endcase
		end
		nx.ready = 1'b1;

		// Software reset returns all top-level state to its reset state; the debounce filters keep theirs
		if (swrst)
			nx = hdp_pkg::TOP_RST;
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			st <= hdp_pkg::TOP_RST;
		else
			st <= nx;
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign hrdata_o = st.rdata;
	assign hreadyout_o = st.ready;
	assign hresp_o = 1'b0;
	assign left_headphone_output_o = st.hpl;
	assign right_headphone_output_o = st.hpr;
	assign virtual_ground_amp_o = st.vg;
	assign speaker_diff_output_o = st.spk;
	assign receiver_diff_output_o = st.rcv;
	assign headset_mic_bias_o = st.mb;
	assign general_io_pin_one_o = st.gp1;
	assign general_io_pin_two_o = st.gp2;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	sequence hp_rise_s;
		hp_req && !st.hp_up && !st.short && !st.pop_dis && !swrst;
	endsequence

	short_off_a: assert property (st.short |=> !(st.hpl || st.hpr || st.vg || st.spk || st.rcv))
		else $error("output on while short state set");
	short_hold_a: assert property (st.short && !(&stat) && !swrst |=> st.short)
		else $error("short state left before recovery");
	sw_reset_a: assert property (swrst |=> !st.short && st.pd == hdp_pkg::PD_RST)
		else $error("software reset did not restore state");
	hp_scdis_a: assert property (st.hp_scdis && !st.short && !short_virtual_ground_amp_i && !short_spk_i
		|=> !st.short)
		else $error("headphone short caught while disabled");
	spk_prot_a: assert property (short_spk_i && st.spk_scen && !swrst |=> st.short)
		else $error("speaker short not caught");
	drv_excl_a: assert property (!(st.rcv && (st.hpl || st.hpr)))
		else $error("receiver and headphone on together");
	hs_force_a: assert property (forced && !swrst |=> !st.hpl && !st.vg && !st.mb)
		else $error("output on without headset");
	hs_pulse_a: assert property (hs_evt && !swrst |=> st.hs_cnt == 3'(hdp_pkg::HS_IRQ_TK))
		else $error("headset pulse length wrong");
	pop_long_a: assert property (hp_rise_s ##0 (!vg_on && st.pop_sel)
		|=> st.ramp == 14'(hdp_pkg::CHG_LONG_TK))
		else $error("long charge time not loaded");
	vg_fast_a: assert property (hp_rise_s ##0 vg_on |=> st.ramp == 14'(hdp_pkg::VG_UP_TK))
		else $error("virtual ground powerup time not loaded");
	btn_hold_a: assert property (st.btn_flag && !(rd_hs && !btn_lvl) && !swrst |=> st.btn_flag)
		else $error("button flag cleared early");
	btn_dly_a: assert property (btn_lvl && !st.btn_lvl && !swrst
		|=> st.bdly == 2'(hdp_pkg::BTN_DLY_TK))
		else $error("button delay not started");

endmodule // hdp_top

// ### verif/hdp_jack_model.sv
// Behavioural model of the headset jack, button and analog short monitors
`timescale 1ns/1ps
module hdp_jack_model
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Bench commands
	input wire logic plug_i,
	input wire logic press_i,
	input wire logic [2:0] short_sel_i,
	// Monitor lines
	output logic headset_sense_o,
	output logic button_sense_o,
	output logic short_hp_o,
	output logic short_virtual_ground_amp_o,
	output logic short_spk_o
);
	// ************************************************************
	// Contact bounce
	// ************************************************************
	// Sleeve contact chatters for a few cycles so the filter has real glitches to reject
	logic plug_q;
	logic [2:0] bounce;
	always @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			plug_q <= 1'b0;
			bounce <= 3'h0;
			headset_sense_o <= 1'b0;
		end
		else if (plug_i !== plug_q)
		begin
			plug_q <= plug_i;
			bounce <= 3'h5;
		end
		else if (bounce != 3'h0)
		begin
			bounce <= bounce - 3'h1;
			headset_sense_o <= (bounce == 3'h1) ? plug_q : ~headset_sense_o;
		end
	end
	assign button_sense_o = press_i;
	assign short_hp_o = short_sel_i[0];
	assign short_virtual_ground_amp_o = short_sel_i[1];
	assign short_spk_o = short_sel_i[2];
endmodule // hdp_jack_model

// ### verif/hdp_top_bench.sv
// Self-checking bench for the headset detect and output protection block
`timescale 1ns/1ps
module hdp_top_bench;
	typedef struct {string nm; logic [31:0] exp; logic [31:0] msk;} hdp_note_t;
	localparam logic [31:0] A_PWR = {22'h0, hdp_pkg::IDX_PWR, 2'b00};
	localparam logic [31:0] A_PROT = {22'h0, hdp_pkg::IDX_PROT, 2'b00};
	localparam logic [31:0] A_HPCFG = {22'h0, hdp_pkg::IDX_HPCFG, 2'b00};
	localparam logic [31:0] A_PCFG = {22'h0, hdp_pkg::IDX_PCFG, 2'b00};
	localparam logic [31:0] A_HS = {22'h0, hdp_pkg::IDX_HS, 2'b00};
	localparam logic [31:0] A_POP = {22'h0, hdp_pkg::IDX_POP, 2'b00};
	logic clk_i, rst_b_i, hsel, hwrite, plug, press, res_stb, dph_rd;
	logic [1:0] htrans;
	logic [2:0] hsize, short_sel;
	logic [31:0] haddr, hwdata, res_val;
	logic [15:0] rnd;
	wire logic [31:0] hrdata;
	wire logic hready, hresp, s_hp, s_vg, s_spk, hs_sense, btn_sense;
	wire logic [7:0] outs;
	hdp_note_t notes[$];
	int miscompares, compares, cyc, n, w, c;
	logic [7:0] snap;

	hdp_top #(.TICK_CYCLES(4)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
		.hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
		.hresp_o(hresp), .short_hp_i(s_hp), .short_virtual_ground_amp_i(s_vg), .short_spk_i(s_spk),
		.headset_sense_i(hs_sense), .button_sense_i(btn_sense),
		.left_headphone_output_o(outs[0]), .right_headphone_output_o(outs[1]),
		.virtual_ground_amp_o(outs[2]), .speaker_diff_output_o(outs[3]),
		.receiver_diff_output_o(outs[4]), .headset_mic_bias_o(outs[5]),
		.general_io_pin_one_o(outs[6]), .general_io_pin_two_o(outs[7]));
	hdp_jack_model jack (.clk_i(clk_i), .rst_b_i(rst_b_i), .plug_i(plug), .press_i(press),
		.short_sel_i(short_sel), .headset_sense_o(hs_sense), .button_sense_o(btn_sense),
		.short_hp_o(s_hp), .short_virtual_ground_amp_o(s_vg), .short_spk_o(s_spk));

	// ************************************************************
	// Tasks
	// ************************************************************
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic finish_test();
		if (miscompares == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Hold each phase until hready is seen high; only the timeout ends a stall
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_i);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		hsize <= 3'b010;
		do @(posedge clk_i); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk_i); while (hready !== 1'b1);
	endtask
	task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] e,
		input logic [31:0] m);
		notes.push_back('{nm, e, m});
		bus(1'b0, a, 32'h0);
	endtask
	task automatic post(input string nm, input logic [31:0] e, input logic [31:0] m,
		input logic [31:0] v);
		notes.push_back('{nm, e, m});
		@(posedge clk_i);
		res_val <= v;
		res_stb <= 1'b1;
		@(posedge clk_i);
		res_stb <= 1'b0;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] m);
		post(nm, {24'h0, e}, {24'h0, m}, {24'h0, outs});
	endtask
	task automatic wt(input int k);
		repeat (k) @(posedge clk_i);
	endtask
	task automatic rise(input int lim, output int k);
		k = 0;
		while (outs[6] !== 1'b1 && k < lim)
		begin
			@(posedge clk_i);
			k++;
		end
	endtask

	// ************************************************************
	// Checker process and clocks
	// ************************************************************
	always @(posedge clk_i)
	begin
		hdp_note_t t;
		if ((dph_rd && hready === 1'b1) || res_stb)
		begin
			compares++;
			t = notes.pop_front();
			if (((dph_rd ? hrdata : res_val) & t.msk) !== (t.exp & t.msk))
			begin
				miscompares++;
				$display("MISMATCH %s expected %h seen %h", t.nm, t.exp & t.msk,
					(dph_rd ? hrdata : res_val) & t.msk);
			end
		end
		dph_rd <= hsel && htrans[1] && hready && !hwrite;
		cyc++;
		if (cyc == 60000)
		begin
			miscompares++;
			finish_test();
		end
	end
	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	initial
	begin
		{rst_b_i, hsel, hwrite, plug, press, res_stb, htrans, hsize} = '0;
		{short_sel, haddr, hwdata, res_val} = '0;
		rnd = 16'hadfa;
		wt(8);
		rst_b_i <= 1'b1;
		rd("pop_status", A_POP, 32'h0000fc00, 32'h0000fc30);
		rd("pwr_reset", A_PWR, 32'h000019c0, 32'h000019c0);
		rd("unmapped", 32'h00000040, 32'h0, 32'hffffffff);
		rd("prot_reset", A_PROT, 32'h0, 32'h3);
		post("hresp_okay", 32'h0, 32'h1, {31'h0, hresp});
		rnd = lfsr(rnd);
		bus(1'b1, A_HPCFG, {16'h0, rnd});
		rd("hpcfg_rw", A_HPCFG, {31'h0, rnd[0]}, 32'h1);
		bus(1'b1, A_HPCFG, 32'h0);
		bus(1'b1, A_POP, 32'h20);
		bus(1'b1, A_PWR, 32'h0180);
		wt(12);
		chk("hp_on_rcv_off", 8'h03, 8'h1f);
		bus(1'b1, A_PWR, 32'h1980);
		wt(12);
		chk("spk_off_rcv_on", 8'h10, 8'h18);
		chk("rcv_only", 8'h10, 8'h13);
		bus(1'b1, A_PWR, 32'h0180);
		wt(12);
		short_sel <= 3'b001;
		wt(4);
		rd("short_set", A_PROT, 32'h2, 32'h2);
		chk("short_off", 8'h00, 8'h3f);
		short_sel <= 3'b000;
		wt(40);
		chk("short_held", 8'h00, 8'h3f);
		rd("short_stays", A_PROT, 32'h2, 32'h2);
		bus(1'b1, A_PWR, 32'h19c0);
		wt(8);
		rd("pd_flags", A_POP, 32'h0000fc00, 32'h0000fc00);
		rd("short_clear", A_PROT, 32'h0, 32'h2);
		bus(1'b1, A_PWR, 32'h0180);
		wt(12);
		chk("hp_back", 8'h03, 8'h1f);
		bus(1'b1, A_HPCFG, 32'h1);
		short_sel <= 3'b001;
		wt(8);
		rd("hp_sc_dis", A_PROT, 32'h0, 32'h2);
		short_sel <= 3'b100;
		wt(8);
		rd("spk_sc_off", A_PROT, 32'h0, 32'h2);
		bus(1'b1, A_PCFG, 32'h20);
		wt(4);
		rd("spk_sc_on", A_PROT, 32'h2, 32'h2);
		// Hardware reset in mid-run must also leave the short state
		rst_b_i <= 1'b0;
		wt(2);
		rst_b_i <= 1'b1;
		rd("hw_reset", A_PROT, 32'h0, 32'h2);
		bus(1'b1, A_PCFG, 32'h20);
		wt(4);
		rd("spk_sc_again", A_PROT, 32'h2, 32'h2);
		short_sel <= 3'b000;
		bus(1'b1, A_PROT, 32'h1);
		rd("sw_reset", A_PROT, 32'h0, 32'h2);
		rd("sw_reset_pop", A_POP, 32'h0000fc00, 32'h0000fc30);
		bus(1'b1, A_PCFG, 32'h10);
		short_sel <= 3'b010;
		wt(8);
		rd("vg_sc_dis", A_PROT, 32'h0, 32'h2);
		short_sel <= 3'b000;
		bus(1'b1, A_PWR, 32'h08c0);
		wt(6);
		chk("vg_ramp_early", 8'h00, 8'h01);
		wt(24);
		chk("vg_ramp_done", 8'h01, 8'h01);
		bus(1'b1, A_PWR, 32'h19c0);
		wt(8);
		bus(1'b1, A_PWR, 32'h09c0);
		wt(12400);
		chk("chg_short_early", 8'h00, 8'h01);
		wt(800);
		chk("chg_short_done", 8'h01, 8'h01);
		bus(1'b1, A_PWR, 32'h19c0);
		bus(1'b1, A_POP, 32'h10);
		bus(1'b1, A_PWR, 32'h09c0);
		wt(13200);
		chk("chg_long", 8'h00, 8'h01);
		// Drop the drivers so the next powerup reloads the ramp with pop reduction off
		bus(1'b1, A_PWR, 32'h19c0);
		bus(1'b1, A_POP, 32'h20);
		bus(1'b1, A_HS, 32'h8118);
		bus(1'b1, A_PWR, 32'h08c0);
		wt(24);
		chk("no_headset", 8'h00, 8'h25);
		plug <= 1'b1;
		rise(600, n);
		snap = outs;
		w = 0;
		while (outs[6] === 1'b1 && w < 200)
		begin
			@(posedge clk_i);
			w++;
		end
		post("hs_pins", 32'hc0, 32'hc0, {24'h0, snap});
		post("hs_irq_len", 32'h1, 32'h1, {31'h0, w >= 24 && w <= 32});
		rd("hs_present", A_HS, 32'h1000, 32'h1000);
		wt(40);
		chk("headset_on", 8'h25, 8'h25);
		bus(1'b1, A_HS, 32'h8708);
		plug <= 1'b0;
		wt(1000);
		rd("hs_db_long", A_HS, 32'h1000, 32'h1000);
		rise(3000, n);
		chk("hs_pin_one", 8'h40, 8'hc0);
		rd("hs_removed", A_HS, 32'h0, 32'h1000);
		wt(40);
		bus(1'b1, A_HS, 32'h0008);
		plug <= 1'b1;
		rise(600, n);
		post("hs_det_off", 32'h0, 32'h1, {31'h0, outs[6]});
		bus(1'b1, A_HS, 32'h0001);
		press <= 1'b1;
		rise(40, n);
		post("btn_dly0", 32'h1, 32'h1, {31'h0, n >= 4 && n <= 16});
		rd("btn_flag", A_HS, 32'h0800, 32'h0800);
		rd("btn_held", A_HS, 32'h0800, 32'h0800);
		press <= 1'b0;
		wt(12);
		chk("btn_irq_end", 8'h00, 8'h40);
		rd("btn_rd_clr", A_HS, 32'h0800, 32'h0800);
		rd("btn_cleared", A_HS, 32'h0, 32'h0800);
		bus(1'b1, A_HS, 32'h0041);
		rnd = lfsr(rnd);
		press <= 1'b1;
		wt(20 + int'(rnd[5:0]));
		press <= 1'b0;
		rise(300, n);
		post("btn_glitch", 32'h0, 32'h1, {31'h0, outs[6]});
		for (c = 1; c < 4; c++)
		begin
			bus(1'b1, A_HS, 32'h0001 | (c << 6));
			press <= 1'b1;
			rise(1000, n);
			post("btn_db", 32'h1, 32'h1, {31'h0, n >= (56 << c) && n <= (72 << c) + 12});
			press <= 1'b0;
			wt(80 << c);
			rd("btn_release", A_HS, 32'h0800, 32'h0800);
		end
		finish_test();
	end
endmodule // hdp_top_bench
